// [logic/fes_bus_if.sv]
// Single flash bus cycle request between the sequencer and the pin driver.
// Assumes both ends run on pclk.
`timescale 1ns/10ps
interface fes_bus_if;
  logic req;
  logic wr;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport ctl(output req, wr, addr, wdata, input done, rdata);
  modport cyc(input req, wr, addr, wdata, output done, rdata);
endinterface

// [logic/fes_cyc.sv]
// Drives one flash write or read cycle on the pins per request.
// Assumes dq_in is already synchronised and req is held until done.
`timescale 1ns/10ps
module fes_cyc (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  // Request port
  fes_bus_if.cyc bus,
  // Flash pins
  input wire logic [15:0] dq_in,
  output logic [23:0] fl_addr,
  output logic [15:0] fl_dq_o,
  output logic fl_dq_oe_n,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n
);
  import fes_pkg::*;
  typedef enum logic [1:0] {C_IDLE, C_SET, C_ACT, C_HOLD} fes_cph_e;
  typedef struct packed {
    fes_cph_e ph;
    logic [3:0] cnt;
    logic wr;
    logic [23:0] addr;
    logic [15:0] dq;
    logic dq_oe_n;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic done;
    logic [15:0] rd;
  } fes_cyc_s;
  fes_cyc_s s, n;
  always_comb begin
    n = s;
    n.done = 1'b0;
    case (s.ph)
      C_IDLE: begin
        // Done blocks a restart while the sequencer still shows the old request
        if (bus.req && !s.done) begin
          n.ph = C_SET;
          n.cnt = SETUP_CYC;
          n.wr = bus.wr;
          n.addr = bus.addr;
          n.dq = bus.wdata;
          n.ce_n = 1'b0;
          n.dq_oe_n = !bus.wr;
        end
      end
      C_SET: begin
        if (s.cnt == 4'd1) begin
          n.ph = C_ACT;
          n.cnt = PULSE_CYC;
          n.we_n = !s.wr;
          n.oe_n = s.wr;
        end else begin
          n.cnt = s.cnt - 4'd1;
        end
      end
      C_ACT: begin
        if (s.cnt == 4'd1) begin
          n.ph = C_HOLD;
          n.cnt = HOLD_CYC;
          n.we_n = 1'b1;
          n.oe_n = 1'b1;
          n.rd = dq_in;
        end else begin
          n.cnt = s.cnt - 4'd1;
        end
      end
      C_HOLD: begin
        if (s.cnt == 4'd1) begin
          n.ph = C_IDLE;
          n.ce_n = 1'b1;
          n.dq_oe_n = 1'b1;
          n.done = 1'b1;
        end else begin
          n.cnt = s.cnt - 4'd1;
        end
      end
      default: n.ph = C_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.dq_oe_n <= 1'b1;
      s.ce_n <= 1'b1;
      s.we_n <= 1'b1;
      s.oe_n <= 1'b1;
    end else if (en) begin
      s <= n;
    end
  end
  assign bus.done = s.done;
  assign bus.rdata = s.rd;
  assign fl_addr = s.addr;
  assign fl_dq_o = s.dq;
  assign fl_dq_oe_n = s.dq_oe_n;
  assign fl_ce_n = s.ce_n;
  assign fl_we_n = s.we_n;
  assign fl_oe_n = s.oe_n;
endmodule

// [logic/fes_host.sv]
// Host sequencer for a parallel NOR flash: erase, suspend, resume, buffer
// program and status polling, ordered through APB registers.
// Assumes a flash on the pins and an APB master on pclk.
`timescale 1ns/10ps
module fes_host #(
  parameter int ERS_GAP = fes_pkg::ERES_GAP_CYC
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash pins
  output logic [23:0] fl_addr,
  output logic [15:0] fl_dq_o,
  input wire logic [15:0] fl_dq_i,
  output logic fl_dq_oe_n,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  output logic fl_reset_n,
  input wire logic ready_busy_n
);
  import fes_pkg::*;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEQ, ST_WAIT, ST_RD, ST_P1, ST_P2
  } fes_st_e;
  typedef struct packed {
    fes_st_e st;
    logic [3:0] op;
    logic [23:0] addr;
    logic [5:0] cnt;
    logic [5:0] idx;
    logic [5:0] fill;
    logic [31:0][15:0] wbuf;
    logic [15:0] rd1;
    logic [15:0] rd;
    logic [15:0] wcnt;
    logic [15:0] gap;
    logic [23:0] psect;
    logic refused;
    logic done;
    logic tlimit;
    logic babort;
    logic chip;
    logic ers;
    logic win;
    logic esus;
    logic prg;
    logic psus;
    logic need_poll;
    logic rstn_o;
    logic [31:0] prdata;
  } fes_host_s;
  fes_host_s s, n;
  fes_bus_if bus ();
  logic [16:0] syn;
  logic acc, bwr, ctrl_wr, mapped, allow, busy_ers, cur_last, sect_hit;
  logic [3:0] wop;
  logic [23:0] cur_a;
  logic [15:0] cur_d;
  logic [5:0] k;
  logic [31:0] rdmux;

  fes_sync #(.W(17)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .en(en),
    .d({ready_busy_n, fl_dq_i}),
    .q(syn)
  );
  fes_cyc u_cyc (
    .pclk(pclk),
    .presetn(presetn),
    .en(en),
    .bus(bus.cyc),
    .dq_in(syn[15:0]),
    .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe_n(fl_dq_oe_n),
    .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n)
  );

  // Command cycles of each operation before any buffer loads
  function automatic logic [40:0] seq_word(input logic [3:0] op,
      input logic [5:0] i, input logic [23:0] sa, input logic [5:0] c);
    logic [23:0] a;
    logic [7:0] d;
    logic last;
    a = (i == 6'd1 || i == 6'd4) ? UNLK_A2 : UNLK_A1;
    d = (i == 6'd1 || i == 6'd4) ? UNLK_D2 : UNLK_D1;
    last = 1'b0;
    case (op)
      OP_CHIP, OP_SECT: begin
        if (i == 6'd2) begin
          d = CMD_ERS_SETUP;
        end else if (i == 6'd5) begin
          last = 1'b1;
          a = (op == OP_CHIP) ? UNLK_A1 : sa;
          d = (op == OP_CHIP) ? CMD_CHIP : CMD_SECT;
        end
      end
      OP_ESUSP, OP_PSUSP, OP_ERES, OP_PRES: begin
        last = 1'b1;
        a = sa;
        d = (op == OP_ESUSP) ? CMD_ESUSP : (op == OP_PSUSP) ? CMD_PSUSP :
            (op == OP_ERES) ? CMD_ERES : CMD_PRES;
      end
      OP_ABORT: begin
        if (i == 6'd2) begin
          last = 1'b1;
          d = CMD_ABORT_RST;
        end
      end
      default: begin
        if (i == 6'd2) begin
          a = sa;
          d = CMD_BUF_LOAD;
        end else if (i == 6'd3) begin
          a = sa;
          d = {2'b00, c};
        end
      end
    endcase
    return {last, a, 8'h00, d};
  endfunction

  assign acc = psel && penable && en;
  assign bwr = acc && pwrite;
  assign ctrl_wr = bwr && paddr == REG_CTRL;
  assign wop = pwdata[3:0];
  assign mapped = paddr == REG_CTRL || paddr == REG_ADDR ||
                  paddr == REG_WDATA || paddr == REG_COUNT ||
                  paddr == REG_STATUS || paddr == REG_RDATA;
  assign pready = en;
  assign pslverr = psel && penable && !mapped;
  assign busy_ers = s.ers && !s.esus;
  assign sect_hit = s.addr[23:SECT_LSB] == s.psect[23:SECT_LSB];
  assign k = s.idx - 6'd4;

  // Which orders the flash may take in its present mode
  always_comb begin
    case (wop)
      OP_POLL: allow = 1'b1;
      OP_READ: allow = !s.chip && !busy_ers && !s.prg &&
                       !(s.psus && sect_hit);
      OP_CHIP: allow = !s.chip && !s.ers && !s.esus && !s.prg &&
                       !s.psus && !s.need_poll && !s.babort;
      OP_SECT: allow = s.win || (!s.chip && !s.ers && !s.esus && !s.prg &&
                       !s.psus && !s.need_poll && !s.babort);
      OP_ESUSP: allow = busy_ers && !s.prg && s.gap == 16'h0000;
      OP_ERES: allow = s.esus && !s.prg;
      OP_BUF: allow = !s.chip && !busy_ers && !s.prg && !s.psus &&
                      !s.need_poll && !s.babort &&
                      s.cnt <= BUF_MAX_M1;
      OP_PSUSP: allow = s.prg && !s.babort && s.gap == 16'h0000;
      OP_PRES: allow = s.psus;
      OP_ABORT: allow = s.babort;
      default: allow = 1'b0;
    endcase
  end

  // Address and data of the current write cycle
  always_comb begin
    {cur_last, cur_a, cur_d} = seq_word(s.op, s.idx, s.addr, s.cnt);
    if (s.op == OP_BUF && s.idx >= 6'd4) begin
      cur_last = 1'b0;
      if (k <= s.cnt) begin
        cur_a = {s.addr[23:PAGE_LSB], 5'(s.addr[4:0] + k[4:0])};
        cur_d = s.wbuf[k[4:0]];
      end else begin
        cur_last = 1'b1;
        cur_a = s.addr;
        cur_d = {8'h00, CMD_BUF_CONF};
      end
    end
  end

  always_comb begin
    case (paddr)
      REG_ADDR: rdmux = {8'h00, s.addr};
      REG_COUNT: rdmux = {26'h0, s.cnt};
      REG_STATUS: rdmux = {10'h0, s.fill, 2'b00, s.gap != 16'h0000,
          s.need_poll, syn[16], s.psus, s.prg, s.esus, s.win, s.ers,
          s.chip, s.babort, s.tlimit, s.done, s.refused,
          s.st != ST_IDLE};
      REG_RDATA: rdmux = {16'h0000, s.rd};
      default: rdmux = 32'h0;
    endcase
  end

  assign bus.req = s.st == ST_SEQ || s.st == ST_RD ||
                   s.st == ST_P1 || s.st == ST_P2;
  assign bus.wr = s.st == ST_SEQ;
  assign bus.addr = (s.st == ST_SEQ) ? cur_a : s.addr;
  assign bus.wdata = cur_d;

  always_comb begin
    n = s;
    n.rstn_o = 1'b1;
    if (psel) begin
      n.prdata = rdmux;
    end
    if (s.gap != 16'h0000) begin
      n.gap = s.gap - 16'd1;
    end
    if (bwr && mapped && s.st != ST_IDLE) begin
      n.refused = 1'b1;
    end else if (bwr) begin
      case (paddr)
        REG_ADDR: n.addr = pwdata[23:0];
        REG_COUNT: n.cnt = pwdata[5:0];
        REG_WDATA: begin
          if (s.fill <= BUF_MAX_M1) begin
            n.wbuf[s.fill[4:0]] = pwdata[15:0];
            n.fill = s.fill + 6'd1;
          end
        end
        REG_CTRL: begin
          if (allow) begin
            n.op = wop;
            n.idx = 6'd0;
            n.refused = 1'b0;
            n.done = 1'b0;
            n.st = (wop == OP_READ) ? ST_RD :
                   (wop == OP_POLL) ? ST_P1 : ST_SEQ;
          end else begin
            n.refused = 1'b1;
          end
        end
        default: ;
      endcase
    end
    case (s.st)
      ST_IDLE: ;
      ST_SEQ: begin
        if (bus.done && !cur_last) begin
          n.idx = s.idx + 6'd1;
        end else if (bus.done) begin
          n.st = ST_IDLE;
          n.done = 1'b1;
          case (s.op)
            OP_CHIP: n.chip = 1'b1;
            OP_SECT: begin
              n.ers = 1'b1;
              n.win = 1'b1;
            end
            OP_ESUSP: begin
              n.win = 1'b0;
              n.st = ST_WAIT;
              n.wcnt = ESUSP_CYC;
            end
            OP_ERES: begin
              n.esus = 1'b0;
              n.gap = 16'(ERS_GAP);
            end
            OP_BUF: begin
              n.prg = 1'b1;
              n.fill = 6'd0;
              n.psect = s.addr;
            end
            OP_PSUSP: begin
              n.st = ST_WAIT;
              n.wcnt = PSUSP_CYC;
            end
            OP_PRES: begin
              n.psus = 1'b0;
              n.prg = 1'b1;
              n.need_poll = 1'b1;
              n.gap = PRES_GAP_CYC;
            end
            OP_ABORT: begin
              n.babort = 1'b0;
              n.prg = 1'b0;
            end
            default: ;
          endcase
        end
      end
      ST_WAIT: begin
        if (s.wcnt != 16'h0000) begin
          n.wcnt = s.wcnt - 16'd1;
        end else if (s.op == OP_ESUSP) begin
          n.esus = 1'b1;
          n.st = ST_IDLE;
        end else begin
          n.psus = 1'b1;
          n.prg = 1'b0;
          n.st = ST_IDLE;
        end
      end
      ST_RD: begin
        if (bus.done) begin
          n.rd = bus.rdata;
          n.st = ST_IDLE;
          n.done = 1'b1;
        end
      end
      ST_P1: begin
        if (bus.done) begin
          n.rd1 = bus.rdata;
          n.st = ST_P2;
        end
      end
      ST_P2: begin
        if (bus.done) begin
          n.rd = bus.rdata;
          n.st = ST_IDLE;
          n.done = 1'b1;
          if (bus.rdata[BIT_TOGGLE] == s.rd1[BIT_TOGGLE]) begin
            // Two equal toggle reads: the embedded operation has ended
            n.tlimit = 1'b0;
            n.prg = 1'b0;
            n.need_poll = 1'b0;
            n.chip = 1'b0;
            if (!s.esus) begin
              n.ers = 1'b0;
              n.win = 1'b0;
            end
          end else begin
            // Time-limit and abort flags need both reads, so array data read
            // just after the operation ends cannot raise them
            n.tlimit = bus.rdata[BIT_TIME_LIMIT] &&
                       s.rd1[BIT_TIME_LIMIT];
            if (bus.rdata[BIT_ERASE_WINDOW]) begin
              n.win = 1'b0;
            end
            if (s.prg && bus.rdata[BIT_BUF_ABORT] &&
                s.rd1[BIT_BUF_ABORT]) begin
              n.babort = 1'b1;
            end
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (en) begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign fl_reset_n = s.rstn_o;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence cmd_s(logic [3:0] o);
    ctrl_wr && wop == o && s.st == ST_IDLE;
  endsequence
  sequence last_done_s(logic [3:0] o);
    s.st == ST_SEQ && s.op == o && bus.done && cur_last;
  endsequence

  chip_six_a: assert property (
    last_done_s(OP_CHIP) |-> s.idx == 6'd5 ##1 s.chip && s.st == ST_IDLE)
    else $error("chip erase not after six cycles");
  chip_ignore_a: assert property (
    s.chip ##0 cmd_s(OP_SECT) |=> s.refused && s.st == ST_IDLE)
    else $error("command taken during chip erase");
  ers_only_susp_a: assert property (
    busy_ers && !s.win ##0 cmd_s(OP_SECT) |=> s.refused)
    else $error("sector erase taken after window");
  susp_gap_a: assert property (
    s.gap != 16'h0000 ##0 cmd_s(OP_ESUSP) |=> s.refused)
    else $error("erase suspend inside resume gap");
  res_mode_a: assert property (
    !s.esus ##0 cmd_s(OP_ERES) |=> s.refused)
    else $error("erase resume outside suspend");
  esus_wait_a: assert property (
    $rose(s.esus) |-> $past(s.st) == ST_WAIT && $past(s.wcnt) == 16'h0000)
    else $error("erase suspend mode entered early");
  buf_count_a: assert property (
    s.cnt > BUF_MAX_M1 ##0 cmd_s(OP_BUF) |=> s.refused)
    else $error("oversized buffer count taken");
  psus_read_a: assert property (
    s.psus && sect_hit ##0 cmd_s(OP_READ) |=> s.refused)
    else $error("read of suspended sector taken");
  prg_poll_a: assert property (
    s.need_poll ##0 cmd_s(OP_BUF) |=> s.refused)
    else $error("program taken before poll after resume");
  conf_cyc_a: assert property (
    last_done_s(OP_BUF) |-> cur_d == {8'h00, CMD_BUF_CONF} ##1 s.prg)
    else $error("buffer program without confirm");
endmodule

// [logic/fes_pkg.sv]
// Constants for the NOR flash erase, suspend and buffer-program host.
// Assumes a 100 MHz pclk; the flash is reached only through fes_host pins.
package fes_pkg;
  localparam int CLK_NS = 10;
  localparam int T_SETUP_NS = 20;
  localparam int T_PULSE_NS = 70;
  localparam int T_HOLD_NS = 30;
  localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam int T_ESUSP_US = 20;
  localparam int T_PSUSP_US = 15;
  localparam int T_ERES_GAP_US = 400;
  localparam int T_PRES_GAP_US = 5;
  localparam logic [15:0] ESUSP_CYC =
    16'((T_ESUSP_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] PSUSP_CYC =
    16'((T_PSUSP_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] PRES_GAP_CYC =
    16'((T_PRES_GAP_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam int ERES_GAP_CYC = (T_ERES_GAP_US * 1000 + CLK_NS - 1) / CLK_NS;
  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  // Operations written to the control register
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_POLL = 4'h2;
  localparam logic [3:0] OP_CHIP = 4'h3;
  localparam logic [3:0] OP_SECT = 4'h4;
  localparam logic [3:0] OP_ESUSP = 4'h5;
  localparam logic [3:0] OP_ERES = 4'h6;
  localparam logic [3:0] OP_BUF = 4'h7;
  localparam logic [3:0] OP_PSUSP = 4'h8;
  localparam logic [3:0] OP_PRES = 4'h9;
  localparam logic [3:0] OP_ABORT = 4'ha;
  // Flash command cycles
  localparam logic [23:0] UNLK_A1 = 24'h000555;
  localparam logic [23:0] UNLK_A2 = 24'h0002aa;
  localparam logic [7:0] UNLK_D1 = 8'haa;
  localparam logic [7:0] UNLK_D2 = 8'h55;
  localparam logic [7:0] CMD_ERS_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SECT = 8'h30;
  localparam logic [7:0] CMD_ESUSP = 8'hb0;
  localparam logic [7:0] CMD_ERES = 8'h30;
  localparam logic [7:0] CMD_PSUSP = 8'hb0;
  localparam logic [7:0] CMD_PRES = 8'h30;
  localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
  localparam logic [7:0] CMD_BUF_CONF = 8'h29;
  localparam logic [7:0] CMD_ABORT_RST = 8'hf0;
  // Status bit positions on the data lines
  localparam int BIT_DATA_POLL = 7;
  localparam int BIT_TOGGLE = 6;
  localparam int BIT_TIME_LIMIT = 5;
  localparam int BIT_ERASE_WINDOW = 3;
  localparam int BIT_BUF_ABORT = 1;
  localparam logic [5:0] BUF_MAX_M1 = 6'd31;
  localparam int SECT_LSB = 16;
  localparam int PAGE_LSB = 5;
endpackage

// [logic/fes_sync.sv]
// Three-stage input synchroniser; a bit changes once stages two and three agree.
// Assumes asynchronous pins as inputs.
`timescale 1ns/10ps
module fes_sync #(
  parameter int W = 17
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  // Raw and filtered levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } fes_sync_s;
  fes_sync_s s, n;
  logic [W-1:0] next_q;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign next_q[i] = (s.s2[i] == s.s3[i]) ? s.s3[i] : s.q[i];
    end
  endgenerate
  always_comb begin
    n = s;
    n.s1 = d;
    n.s2 = s.s1;
    n.s3 = s.s2;
    n.q = next_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (en) begin
      s <= n;
    end
  end
  assign q = s.q;
endmodule

// [verif/fes_flash_model.sv]
// Behavioural NOR flash seen on the fes_host pins.
// Assumes one host; timers settle lazily at each pin event.
`timescale 1ns/10ps
module fes_flash_model (
  // Host side
  input wire logic [23:0] fl_addr,
  input wire logic [15:0] fl_dq_o,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n,
  input wire logic fl_reset_n,
  // Device side
  output logic [15:0] fl_dq_i,
  output logic ready_busy_n
);
  // 0 read,1 window,2 erase,3 erase susp,4 chip,5 program,6 prog susp
  int st = 0;
  int bn = -1;
  int cnt;
  bit tog, loc, un, ab;
  // Sector that refuses erase
  localparam int PROT = 127;
  time te;
  bit ers[int];
  logic [15:0] mem[int];
  logic [23:0] la[$], pa[$];
  logic [7:0] ld[$];
  logic [15:0] pd[$];
  logic [39:0] h = 0;
  logic [15:0] rv = 0;
  logic [7:0] d;
  assign ready_busy_n = st inside {0, 3, 6};
  function automatic logic [15:0] rd(int a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  function automatic void upd();
    int k[$];
    if (st == 1 && $time >= te) begin
      st = 2;
      te = $time + 30000;
      if (ers.size() == 1 && ers.exists(PROT)) te = $time + 1000;
    end
    if (st inside {2, 4, 5} && $time >= te && !ab) begin
      foreach (mem[a])
        if (ers.exists(a >> 16) && a >> 16 != PROT) k.push_back(a);
      foreach (k[i]) mem.delete(k[i]);
      ers.delete();
      st = 0;
    end
  endfunction
  always @(posedge fl_we_n) begin
    upd();
    d = fl_dq_o[7:0];
    un = h == 40'haa5580aa55;
    la.push_back(fl_addr);
    ld.push_back(d);
    if (st != 4) begin
      if (d == 8'hb0 && st inside {1, 2, 5}) begin
        st = st == 5 ? 6 : 3;
      end else if (d == 8'h30 && !un && st inside {3, 6}) begin
        st = st == 3 ? 2 : 5;
        te = $time + 2000;
      end else if (un && d == 8'h10 && st == 0) begin
        mem.delete();
        st = 4;
        te = $time + 30000;
      end else if (un && d == 8'h30 && st < 2) begin
        ers[fl_addr >> 16] = 1;
        st = 1;
        te = $time + 50000;
      end else if (bn == -2) begin
        cnt = d;
        ab = d > 31;
        bn = 0;
        pa = {};
        pd = {};
      end else if (bn >= 0 && bn <= cnt) begin
        ab |= pa.size() > 0 && fl_addr[23:5] != pa[0][23:5];
        pa.push_back(fl_addr);
        pd.push_back(fl_dq_o);
        bn++;
      end else if (bn > cnt) begin
        if (!ab) foreach (pa[i]) mem[pa[i]] = rd(pa[i]) & pd[i];
        st = 5;
        te = $time + 3000;
        bn = -1;
      end else if (h[15:0] == 16'haa55 && d == 8'h25 && st == 0) begin
        bn = -2;
      end else if (ab && h[15:0] == 16'haa55 && d == 8'hf0) begin
        ab = 0;
        st = 0;
      end else if (st == 1 && !(d inside {8'haa, 8'h55, 8'h80})) begin
        st = 0;
      end
    end
    h = {h[31:0], d};
  end
  always @(negedge fl_oe_n) begin
    upd();
    if (st == 0 || st == 6 || (st == 3 && !ers.exists(fl_addr >> 16))) begin
      rv = rd(fl_addr);
    end else begin
      loc ^= st == 4 || ers.exists(fl_addr >> 16);
      tog ^= st != 3;
      rv = {8'h0, st == 3 || (st == 5 && !pd[$][7]), tog, 2'b0, st != 1,
        loc, ab, 1'b0};
    end
    fl_dq_i = rv;
  end
  // Released bus shows the inverse of the last word
  always @(posedge fl_oe_n) fl_dq_i = ~rv;
  always @(negedge fl_reset_n) begin
    st = 0;
    bn = -1;
    ab = 0;
  end
  initial fl_dq_i = 16'h0;
endmodule

// [verif/test_fes_host.sv]
// Self-checking bench: fes_host driving a behavioural flash.
// Assumes pclk at 100 MHz and the flash model on the pins.
`timescale 1ns/10ps
module test_fes_host;
  import fes_pkg::*;
  typedef struct {
    logic [3:0] op;
    logic [23:0] a;
    logic [15:0] d;
    logic [31:0] x;
    logic [15:0] rd;
  } fes_row_s;
  fes_row_s rows[5] = '{
    '{OP_BUF, 24'h020000, 16'h1234, 32'h02000029, 16'h1234},
    '{OP_BUF, 24'h020000, 16'h0ff0, 32'h02000029, 16'h0230},
    '{OP_CHIP, 24'h020000, 16'h0, 32'h00055510, 16'hffff},
    '{OP_BUF, 24'h020000, 16'h00ff, 32'h02000029, 16'h00ff},
    '{OP_SECT, 24'h020000, 16'h0, 32'h02000030, 16'hffff}
  };
  logic pclk, presetn, en, psel, penable, pwrite, slv, pready, pslverr;
  logic fl_dq_oe_n, fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n, ready_busy_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, stat;
  logic [23:0] fl_addr;
  logic [15:0] fl_dq_o, fl_dq_i;
  int error_cnt = 0;
  int samples_checked = 0;
  int n;
  fes_host #(.ERS_GAP(50)) i_fes_host (.pclk(pclk), .presetn(presetn),
    .en(en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
    .fl_dq_i(fl_dq_i), .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_reset_n(fl_reset_n),
    .ready_busy_n(ready_busy_n));
  fes_flash_model fm (.fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
    .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
    .fl_reset_n(fl_reset_n), .fl_dq_i(fl_dq_i),
    .ready_busy_n(ready_busy_n));
  task automatic test_done();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic die();
    error_cnt++;
    test_done();
  endtask
  task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    slv = pslverr;
    if (k == 20) die();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic waitst(int b, logic v);
    for (int k = 0; k < 3000; k++) begin
      apb(1'b0, REG_STATUS, 32'h0);
      stat = r;
      if (stat[b] === v) return;
    end
    die();
  endtask
  task automatic cmd(logic [3:0] op);
    apb(1'b1, REG_CTRL, {28'h0, op});
    waitst(0, 1'b0);
  endtask
  task automatic poll_done();
    for (int k = 0; k < 1000; k++) begin
      cmd(OP_POLL);
      if (stat[6:5] === 2'b0 && stat[9] === 1'b0) return;
    end
    die();
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      fm.la.delete();
      fm.ld.delete();
      apb(1'b1, REG_ADDR, {8'h0, rows[i].a});
      apb(1'b1, REG_COUNT, 32'h0);
      if (rows[i].op == OP_BUF) apb(1'b1, REG_WDATA, {16'h0, rows[i].d});
      cmd(rows[i].op);
      n = fm.ld.size();
      chk("cycles", n, 6);
      chk("unlock", {fm.la[0], fm.ld[0], fm.la[1], fm.ld[1]},
        {UNLK_A1, UNLK_D1, UNLK_A2, UNLK_D2});
      chk("final", {fm.la[n-1], fm.ld[n-1]}, rows[i].x);
      poll_done();
      chk("idle", fm.st, 0);
      chk("tlimit", stat[3], 0);
      cmd(OP_READ);
      apb(1'b0, REG_RDATA, 32'h0);
      chk("rdata", r[15:0], rows[i].rd);
    end
    // Orders other than poll while a chip erase runs stay off the pins
    cmd(OP_CHIP);
    fm.ld.delete();
    cmd(OP_SECT);
    chk("chip refuse", stat[1], 1);
    chk("chip quiet", fm.ld.size(), 0);
    poll_done();
    // Suspend inside the window, then refusals, resume and resume gap
    cmd(OP_SECT);
    cmd(OP_ESUSP);
    waitst(8, 1'b1);
    chk("susp", fm.st, 3);
    cmd(OP_SECT);
    chk("susp sect", stat[1], 1);
    cmd(OP_CHIP);
    chk("susp chip", stat[1], 1);
    cmd(OP_ERES);
    chk("resume", {stat[1], fm.st[3:0]}, 5'h02);
    cmd(OP_ESUSP);
    chk("gap", stat[1], 1);
    poll_done();
    // Program suspend, refused read, resume gap and poll before program
    apb(1'b1, REG_WDATA, 32'h5a5a);
    cmd(OP_BUF);
    cmd(OP_PSUSP);
    waitst(10, 1'b1);
    chk("psus", {stat[11], fm.st[3:0]}, 5'h16);
    cmd(OP_READ);
    chk("psus read", stat[1], 1);
    cmd(OP_PRES);
    cmd(OP_PSUSP);
    chk("pres gap", stat[1], 1);
    cmd(OP_BUF);
    chk("pres poll", stat[1], 1);
    poll_done();
    cmd(OP_ABORT);
    chk("abort refuse", stat[1], 1);
    cmd(OP_READ);
    apb(1'b0, REG_RDATA, 32'h0);
    chk("prog rdata", r[15:0], 16'h5a5a);
    // Reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("rst pins", {fl_reset_n, fl_ce_n, fl_we_n, fl_oe_n, fl_dq_oe_n},
      5'h0f);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("rst status", r, 32'h800);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", slv, 1);
    // Enable low holds the bus off and the pins as they are
    en <= 1'b0;
    @(posedge pclk);
    chk("freeze", {pready, fl_reset_n}, 2'b01);
    en <= 1'b1;
    test_done();
  end
endmodule
